/* File: logic/sfm_map.svh */
// register map, field positions, reset values and timing figures of the safety fault monitor
`ifndef SFM_MAP_SVH
`define SFM_MAP_SVH
`define SFM_OFF_CTRL 8'h00
`define SFM_OFF_ROUTE 8'h04
`define SFM_OFF_STATUS 8'h08
`define SFM_OFF_STATE 8'h0c
`define SFM_CTRL_RST 16'h5600
`define SFM_ROUTE_RST 28'h0000000
`define SFM_STATUS_RST 11'h000
`define SFM_GO_BIT 16
`define SFM_CFG_MCU 2'h1
`define SFM_CFG_EXT 2'h2
`define SFM_FLG_PAIR 0
`define SFM_FLG_A 1
`define SFM_FLG_B 2
`define SFM_FLG_EXT 3
`define SFM_FLG_HI 5
`define SFM_FLG_LO 8
`define SFM_CLK_NS 8
`define SFM_MS_NS 1000000
`define SFM_ACK_MS_0 1
`define SFM_ACK_MS_1 8
`define SFM_ACK_MS_2 16
`define SFM_ACK_MS_3 32
`define SFM_MCU_PULSE_MS 8
`define SFM_WDG_PULSE_MS 10
`define SFM_WDG_WIN_MS 1024
`define SFM_WDG_BAD_STEP 5'h02
`define SFM_ERR_LIM_0 5'h08
`define SFM_ERR_LIM_1 5'h06
`define SFM_ERR_LIM_2 5'h04
`define SFM_ERR_LIM_3 5'h02
`define SFM_RESP_OK 2'h0
`define SFM_RESP_ERR 2'h2
`endif

/* File: logic/sfm_pkg.sv */
// types shared by the safety fault monitor
`default_nettype none
package sfm_pkg;
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_TEST = 4'h2,
        ST_INIT = 4'h4,
        ST_NORM = 4'h8
    } sfm_state_t;

    typedef struct packed {
        logic [1:0] err_limit;
        logic [1:0] pin3_cfg;
        logic [1:0] pin2_cfg;
        logic [1:0] pin1_cfg;
        logic [1:0] ack_time;
        logic ext_pol2;
        logic ext_pol1;
        logic pol_b;
        logic pol_a;
        logic pair_pol;
        logic bistable;
    } sfm_ctrl_t;

    typedef struct packed {
        logic [1:0] wdg_pok;
        logic [1:0] mcu_pok;
        logic [11:0] rail2;
        logic [11:0] rail1;
    } sfm_route_t;

    typedef struct packed {
        logic [5:0] uv;
        logic [5:0] ov;
    } sfm_rail_t;
endpackage
`default_nettype wire

/* File: logic/sfm_monitor.sv */
// safety fault monitor: mcu fault pins, external error pins, power-ok and safe-state outputs
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sfm_map.svh"
module sfm_monitor
    import sfm_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `SFM_MS_NS / `SFM_CLK_NS
) (
    // clock, reset, clock enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device pins and internal monitors
    input wire logic [2:0] general_pin,
    input wire logic supply_valid,
    input wire logic regulator_enable_pin_1,
    input wire logic regulator_enable_pin_2,
    input wire logic self_test_run,
    input wire sfm_rail_t rail_event,
    input wire logic wdg_refresh_ok,
    input wire logic wdg_refresh_bad,
    // output pins and their readback
    input wire logic [1:0] power_ok_fb,
    input wire logic safe_out_fb,
    output logic [1:0] power_ok_out,
    output logic safe_state_out_n,
    output logic wdg_halt,
    output logic wdg_restart
);
    localparam logic [31:0] MCU_CYC = `SFM_MCU_PULSE_MS * MS_CYCLES;
    localparam logic [31:0] WDG_CYC = `SFM_WDG_PULSE_MS * MS_CYCLES;
    localparam logic [31:0] WIN_CYC = `SFM_WDG_WIN_MS * MS_CYCLES;

    function automatic logic [3:0] reg_sel(input logic [7:0] a);
        case (a)
            `SFM_OFF_CTRL: reg_sel = 4'h1;
            `SFM_OFF_ROUTE: reg_sel = 4'h2;
            `SFM_OFF_STATUS: reg_sel = 4'h4;
            `SFM_OFF_STATE: reg_sel = 4'h8;
            default: reg_sel = 4'h0;
        endcase
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            strb_mask[i*8 +: 8] = {8{s[i]}};
        end
    endfunction

    function automatic logic [31:0] ack_cycles(input logic [1:0] sel);
        case (sel)
            2'h0: ack_cycles = `SFM_ACK_MS_0 * MS_CYCLES;
            2'h1: ack_cycles = `SFM_ACK_MS_1 * MS_CYCLES;
            2'h2: ack_cycles = `SFM_ACK_MS_2 * MS_CYCLES;
            default: ack_cycles = `SFM_ACK_MS_3 * MS_CYCLES;
        endcase
    endfunction

    function automatic logic [4:0] err_limit(input logic [1:0] sel);
        case (sel)
            2'h0: err_limit = `SFM_ERR_LIM_0;
            2'h1: err_limit = `SFM_ERR_LIM_1;
            2'h2: err_limit = `SFM_ERR_LIM_2;
            default: err_limit = `SFM_ERR_LIM_3;
        endcase
    endfunction

    sfm_state_t state_r, state_nxt;
    sfm_ctrl_t ctrl_r;
    sfm_route_t route_r;
    logic [10:0] status_r, flag_set, status_clr;
    logic go_r;
    logic [2:0] pin_s1_r, pin_s2_r;
    logic aw_have_r, w_have_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic [31:0] rd_data;
    logic [1:0] ext_prev_r, ext_fault, ext_evt, ack_exp, pok_nxt, pok_prev_r;
    logic [31:0] ack_cnt_r [2];
    logic [31:0] mcu_cnt_r [2];
    logic [31:0] wdg_cnt_r [2];
    logic [31:0] win_cnt_r;
    logic win_done_r;
    logic [3:0] err_cnt_r, fault_cnt_r;
    logic safe_prev_r;

    // pins are asynchronous; only the second stage is looked at
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else if (ce) begin
            pin_s1_r <= general_pin;
            pin_s2_r <= pin_s1_r;
        end
    end

    wire mcu_a_en = ctrl_r.pin2_cfg == `SFM_CFG_MCU;
    wire mcu_b_en = ctrl_r.pin3_cfg == `SFM_CFG_MCU;
    wire [1:0] ext_en = {ctrl_r.pin3_cfg == `SFM_CFG_EXT, ctrl_r.pin1_cfg == `SFM_CFG_EXT};
    wire [1:0] ext_pol = {ctrl_r.ext_pol2, ctrl_r.ext_pol1};
    wire [1:0] ext_lvl = {pin_s2_r[2], pin_s2_r[0]};
    wire pair_mode = mcu_a_en && mcu_b_en && ctrl_r.bistable;
    wire is_norm = state_r == ST_NORM;
    wire pair_fault = pair_mode
        && ((pin_s2_r[1] == ctrl_r.pair_pol) || (pin_s2_r[2] != ctrl_r.pair_pol));
    wire fault_a = !pair_mode && mcu_a_en && (pin_s2_r[1] == ctrl_r.pol_a);
    wire fault_b = !pair_mode && mcu_b_en && (pin_s2_r[2] == ctrl_r.pol_b);
    wire mcu_evt = is_norm && (pair_fault || fault_a || fault_b);
    wire off_cond = supply_valid && !regulator_enable_pin_1 && !regulator_enable_pin_2;

    assign ext_fault = ext_en & ~(ext_lvl ^ ext_pol);
    assign ext_evt = {2{is_norm}} & ext_fault & ~ext_prev_r;

    // register bus write side
    wire wr_do = aw_have_r && w_have_r && !s_axi_bvalid;
    wire [3:0] wr_sel = reg_sel(aw_addr_r);
    wire [31:0] wr_mask = strb_mask(w_strb_r);
    // lane 0 carries the protected fields, so a write touching it is refused outside the init run
    wire ctrl_reject = wr_sel[0] && w_strb_r[0] && (state_r != ST_INIT);
    wire ctrl_wr = wr_do && wr_sel[0] && !ctrl_reject;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SFM_RESP_OK;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == 4'h0 || ctrl_reject) ? `SFM_RESP_ERR : `SFM_RESP_OK;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // register bus read side
    always_comb begin
        case (reg_sel(s_axi_araddr))
            4'h1: rd_data = {16'h0, ctrl_r};
            4'h2: rd_data = {4'h0, route_r};
            4'h4: rd_data = {21'h0, status_r};
            4'h8: rd_data = {15'h0, safe_state_out_n, power_ok_out, wdg_halt, win_done_r,
                             err_cnt_r, fault_cnt_r, state_r};
            default: rd_data = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SFM_RESP_OK;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= (reg_sel(s_axi_araddr) == 4'h0) ? `SFM_RESP_ERR : `SFM_RESP_OK;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `SFM_CTRL_RST;
            route_r <= `SFM_ROUTE_RST;
            go_r <= 1'b0;
        end else if (ce) begin
            go_r <= ctrl_wr && w_strb_r[2] && w_data_r[`SFM_GO_BIT];
            if (ctrl_wr) begin
                ctrl_r <= (ctrl_r & ~wr_mask[15:0]) | (w_data_r[15:0] & wr_mask[15:0]);
            end
            if (wr_do && wr_sel[1]) begin
                route_r <= (route_r & ~wr_mask[27:0]) | (w_data_r[27:0] & wr_mask[27:0]);
            end
        end
    end

    // status flags: a set in the clearing cycle survives
    assign status_clr = (wr_do && wr_sel[2]) ? (w_data_r[10:0] & wr_mask[10:0]) : 11'h000;
    wire [2:0] out_cmd = {safe_state_out_n, power_ok_out};
    wire [2:0] out_prev = {safe_prev_r, pok_prev_r};
    wire [2:0] out_fb = {safe_out_fb, power_ok_fb};
    // the high check runs only in self test; the low check waits one settle cycle
    wire [2:0] stuck_hi = {3{state_r == ST_TEST}} & ~out_cmd & out_fb;
    wire [2:0] stuck_lo = out_cmd & out_prev & ~out_fb;
    assign flag_set = {stuck_lo, stuck_hi, ext_evt,
                       is_norm && fault_b, is_norm && fault_a, is_norm && pair_fault};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= `SFM_STATUS_RST;
            ext_prev_r <= 2'h0;
            pok_prev_r <= 2'h0;
            safe_prev_r <= 1'b0;
        end else if (ce) begin
            status_r <= (status_r & ~status_clr) | flag_set;
            ext_prev_r <= ext_fault;
            pok_prev_r <= power_ok_out;
            safe_prev_r <= safe_state_out_n;
        end
    end

    // acknowledge timers and power-ok pulse timers
    wire [31:0] ack_lim = ack_cycles(ctrl_r.ack_time);
    wire wdg_bad_v = wdg_refresh_bad && !wdg_halt;
    wire wdg_ok_v = wdg_refresh_ok && !wdg_halt;
    wire [4:0] err_sum = {1'b0, err_cnt_r} + `SFM_WDG_BAD_STEP;
    wire wdg_fail = wdg_bad_v && (!win_done_r || err_sum >= err_limit(ctrl_r.err_limit));
    logic [1:0] wdg_act;

    for (genvar gi = 0; gi < 2; gi++) begin : g_chan
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ack_cnt_r[gi] <= 32'h0;
            end else if (ce) begin
                if (!status_r[`SFM_FLG_EXT + gi]) begin
                    ack_cnt_r[gi] <= 32'h0;
                end else if (ack_cnt_r[gi] != ack_lim) begin
                    ack_cnt_r[gi] <= ack_cnt_r[gi] + 32'h1;
                end
            end
        end
        assign ack_exp[gi] = status_r[`SFM_FLG_EXT + gi] && (ack_cnt_r[gi] == ack_lim - 32'h1);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mcu_cnt_r[gi] <= 32'h0;
                wdg_cnt_r[gi] <= 32'h0;
            end else if (ce) begin
                if (mcu_evt && route_r.mcu_pok[gi]) begin
                    mcu_cnt_r[gi] <= MCU_CYC;
                end else if (mcu_cnt_r[gi] != 32'h0) begin
                    mcu_cnt_r[gi] <= mcu_cnt_r[gi] - 32'h1;
                end
                if (wdg_fail && route_r.wdg_pok[gi]) begin
                    wdg_cnt_r[gi] <= WDG_CYC;
                end else if (wdg_cnt_r[gi] != 32'h0) begin
                    wdg_cnt_r[gi] <= wdg_cnt_r[gi] - 32'h1;
                end
            end
        end
        assign wdg_act[gi] = wdg_cnt_r[gi] != 32'h0;
        wire rail_hit = |((gi == 0 ? route_r.rail1 : route_r.rail2) & rail_event);
        assign pok_nxt[gi] = !(rail_hit || mcu_cnt_r[gi] != 32'h0 || wdg_act[gi]
                               || state_nxt == ST_TEST);
    end

    // watchdog error accounting; timing and answer checks live elsewhere
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_cnt_r <= 32'h0;
            win_done_r <= 1'b0;
            err_cnt_r <= 4'h0;
            fault_cnt_r <= 4'h0;
            wdg_halt <= 1'b0;
            wdg_restart <= 1'b0;
        end else if (ce) begin
            if (!win_done_r) begin
                win_cnt_r <= win_cnt_r + 32'h1;
                win_done_r <= win_cnt_r == WIN_CYC - 32'h1;
            end
            if (wdg_bad_v) begin
                err_cnt_r <= wdg_fail ? 4'h0 : err_sum[3:0];
            end else if (wdg_ok_v && err_cnt_r != 4'h0) begin
                err_cnt_r <= err_cnt_r - 4'h1;
            end
            if (wdg_fail && fault_cnt_r != 4'hf) begin
                fault_cnt_r <= fault_cnt_r + 4'h1;
            end
            wdg_halt <= |wdg_act;
            wdg_restart <= wdg_halt && !(|wdg_act);
        end
    end

    // state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (!off_cond) state_nxt = ST_TEST;
            end
            ST_TEST: begin
                if (!self_test_run) state_nxt = ST_INIT;
            end
            ST_INIT: begin
                if (go_r && !(|ext_fault)) state_nxt = ST_NORM;
            end
            ST_NORM: begin
                if (mcu_evt || (|ack_exp)) state_nxt = ST_INIT;
            end
            default: state_nxt = ST_OFF;
        endcase
        if (off_cond) state_nxt = ST_OFF;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_OFF;
            safe_state_out_n <= 1'b0;
            power_ok_out <= 2'h0;
        end else if (ce) begin
            state_r <= state_nxt;
            safe_state_out_n <= state_nxt == ST_NORM;
            power_ok_out <= pok_nxt;
        end
    end

    a_safe_only_norm: assert property (@(posedge aclk) disable iff (!aresetn)
        safe_state_out_n |-> state_r == ST_NORM) else $error("safe output high outside normal");
    a_off_holds_low: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && off_cond |=> !safe_state_out_n && state_r == ST_OFF)
        else $error("safe output not held low with enables low");
    a_mcu_exit_init: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && mcu_evt && !off_cond |=> state_r == ST_INIT && !safe_state_out_n)
        else $error("mcu fault did not return to init run");
    a_mcu_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !is_norm |=> !$rose(status_r[`SFM_FLG_A]) && !$rose(status_r[`SFM_FLG_B])
            && !$rose(status_r[`SFM_FLG_PAIR]))
        else $error("mcu fault flag set outside normal");
    a_pair_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && is_norm && pair_mode && pin_s2_r[2] != ctrl_r.pair_pol |=> status_r[`SFM_FLG_PAIR])
        else $error("pair fault not flagged");
    a_ack_expiry: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && is_norm && (|ack_exp) && !off_cond |=> state_r == ST_INIT ##0 !safe_state_out_n)
        else $error("unacknowledged error did not drop safe output");
    a_mcu_pulse_load: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && mcu_evt && route_r.mcu_pok[0] |=> mcu_cnt_r[0] == MCU_CYC ##1 !power_ok_out[0] || !ce)
        else $error("mcu fault pulse not started");
    a_fault_count: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wdg_fail && fault_cnt_r != 4'hf |=> fault_cnt_r == $past(fault_cnt_r) + 4'h1)
        else $error("fault event count not incremented");
    a_err_step: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wdg_bad_v && !wdg_fail |=> err_cnt_r == $past(err_cnt_r) + 4'h2)
        else $error("bad refresh did not add two");
    a_early_fail: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wdg_bad_v && !win_done_r |=> err_cnt_r == 4'h0 && fault_cnt_r != 4'h0)
        else $error("bad refresh in first window not a failure");
    a_ctrl_protect: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wr_do && wr_sel[0] && w_strb_r[0] && is_norm
        |=> $stable(ctrl_r[3:0]) && s_axi_bresp == `SFM_RESP_ERR)
        else $error("protected setting written outside init run");
    a_stuck_high: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && state_r == ST_TEST && !power_ok_out[0] && power_ok_fb[0]
        |=> status_r[`SFM_FLG_HI])
        else $error("stuck-high not reported in self test");
endmodule
`default_nettype wire

/* File: tb/sfm_mcu_model.sv */
// behavioural microcontroller and pin model on the far side of the safety fault monitor
`timescale 1ns/1ps
`default_nettype none
module sfm_mcu_model (
    // clock of the bench
    input wire logic aclk,
    // pin levels and stuck pins commanded by the bench
    input wire logic [2:0] cmd,
    input wire logic [2:0] stuck,
    input wire logic [2:0] stuck_hi,
    // device pins and their readback
    output logic [2:0] general_pin,
    input wire logic [1:0] power_ok_out,
    input wire logic safe_state_out_n,
    output logic [1:0] power_ok_fb,
    output logic safe_out_fb
);
    initial general_pin = 3'h0;
    // pins move off the edge: the device must not rely on their phase
    always @(posedge aclk) general_pin <= #3 cmd;
    // outputs are pulled up; a stuck pin reads low or high whatever the command
    assign power_ok_fb = (power_ok_out & ~stuck[1:0]) | stuck_hi[1:0];
    assign safe_out_fb = (safe_state_out_n & ~stuck[2]) | stuck_hi[2];
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench of the safety fault monitor
`timescale 1ns/1ps
`default_nettype none
`include "sfm_map.svh"
module tb_top;
    import sfm_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic bvalid, arready, rvalid, safe, safe_fb, halt, sv, en1, st, bad, ok, rs;
    sfm_rail_t rail;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d, v;
    logic [1:0] bresp, rresp, rsp, pok, pok_fb;
    logic [2:0] pins, cmd, stuck, sh;
    int errors, n_checks, seed;

    sfm_monitor #(.MS_CYCLES(10)) dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .general_pin(pins), .supply_valid(sv), .regulator_enable_pin_1(en1),
        .regulator_enable_pin_2(1'b0), .self_test_run(st), .rail_event(rail),
        .wdg_refresh_ok(ok), .wdg_refresh_bad(bad), .power_ok_fb(pok_fb),
        .safe_out_fb(safe_fb), .power_ok_out(pok), .safe_state_out_n(safe),
        .wdg_halt(halt), .wdg_restart(rs));
    sfm_mcu_model mcu (.aclk(aclk), .cmd(cmd), .stuck(stuck), .stuck_hi(sh), .general_pin(pins),
        .power_ok_out(pok), .safe_state_out_n(safe), .power_ok_fb(pok_fb),
        .safe_out_fb(safe_fb));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // power-ok level with no pulse running: low when any enabled rail event is up
    function automatic logic [1:0] exp_pok(input logic [31:0] r, input logic [11:0] e);
        exp_pok = {~|(r[23:12] & e), ~|(r[11:0] & e)};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // address and data offered together, each released once taken
    task wr(input logic [7:0] a, input logic [31:0] x);
        @(posedge aclk);
        awaddr <= a;
        wdata <= x;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                rsp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                rsp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #150000;
        errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        end_sim;
    end

    initial begin
        seed = 72859;
        {errors, n_checks} = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, en1, bad, ok} = 0;
        {awaddr, araddr, wdata, cmd, stuck, sh, rail} = 0;
        {sv, st} = 2'b11;
        step(4);
        aresetn <= 1'b1;
        rd(`SFM_OFF_STATE);
        chk(d & 32'hf, 32'(ST_OFF));
        chk(32'(safe), 32'h0);
        rd(`SFM_OFF_CTRL);
        chk(d, 32'(`SFM_CTRL_RST));
        en1 <= 1'b1;
        step(3);
        st <= 1'b0;
        step(6);
        rd(`SFM_OFF_STATE);
        chk(d & 32'hf, 32'(ST_INIT));
        // reset polarity makes low pins a fault, yet nothing is flagged outside normal
        rd(`SFM_OFF_STATUS);
        chk(d, 32'h0);
        wr(`SFM_OFF_CTRL, 32'h561c);
        chk(32'(rsp), 32'(`SFM_RESP_OK));
        rd(8'h10);
        chk(32'(rsp), 32'(`SFM_RESP_ERR));
        for (int i = 0; i < 4; i++) begin
            v = $random(seed) & 32'hfffffff;
            wr(`SFM_OFF_ROUTE, v);
            rd(`SFM_OFF_ROUTE);
            chk(d, v);
            rail <= sfm_rail_t'(12'($random(seed)));
            step(2);
            chk(32'(pok), 32'(exp_pok(v, rail)));
        end
        wr(`SFM_OFF_ROUTE, 32'h5000000);
        // events whose enables are all clear must leave both outputs high
        rail <= sfm_rail_t'(12'hfff);
        step(2);
        chk(32'(pok), 32'h3);
        rail <= sfm_rail_t'(12'h000);
        $display("test init and config done");
        wr(`SFM_OFF_CTRL, 32'h1561c);
        step(3);
        chk(32'(safe), 32'h1);
        wr(`SFM_OFF_CTRL, 32'h5600);
        chk(32'(rsp), 32'(`SFM_RESP_ERR));
        rd(`SFM_OFF_CTRL);
        chk(d, 32'h561c);
        cmd <= 3'b010;
        step(8);
        chk(32'(safe), 32'h0);
        chk(32'(pok[0]), 32'h0);
        cmd <= 3'b000;
        rd(`SFM_OFF_STATE);
        chk(d & 32'hf, 32'(ST_INIT));
        rd(`SFM_OFF_STATUS);
        chk(d, 32'h2);
        wr(`SFM_OFF_STATUS, 32'h2);
        rd(`SFM_OFF_STATUS);
        chk(d, 32'h0);
        step(90);
        chk(32'(pok[0]), 32'h1);
        $display("test mcu fault done");
        wr(`SFM_OFF_CTRL, 32'h1561c);
        step(3);
        cmd <= 3'b001;
        // pin model edge, 2 sync stages + flag edge, then 1 ms of 10 cycles: safe drops on the 14th edge
        step(13);
        chk(32'(safe), 32'h1);
        step(2);
        chk(32'(safe), 32'h0);
        cmd <= 3'b000;
        rd(`SFM_OFF_STATUS);
        chk(d, 32'h8);
        wr(`SFM_OFF_STATUS, 32'h8);
        $display("test external error done");
        bad <= 1'b1;
        step(1);
        bad <= 1'b0;
        step(4);
        chk({30'h0, halt, pok[0]}, 32'h2);
        rd(`SFM_OFF_STATE);
        chk((d >> 4) & 32'hf, 32'h1);
        // halt rose on the 2nd edge after the failure and lasts 10 ms of 10 cycles
        step(94);
        chk({30'h0, halt, rs}, 32'h2);
        step(1);
        chk({30'h0, halt, rs}, 32'h1);
        chk(32'(pok[0]), 32'h1);
        step(1);
        chk(32'(rs), 32'h0);
        $display("test watchdog done");
        // bi-stable pair, polarity 0: a high and b low is the healthy pattern
        cmd <= 3'b010;
        wr(`SFM_OFF_CTRL, 32'h1561d);
        step(3);
        stuck <= 3'b100;
        step(5);
        rd(`SFM_OFF_STATUS);
        chk(d, 32'h400);
        rd(`SFM_OFF_STATE);
        chk(d & 32'hf, 32'(ST_NORM));
        $display("test stuck pin done");
        cmd <= 3'b110;
        step(8);
        chk(32'(safe), 32'h0);
        chk(32'(pok[0]), 32'h0);
        rd(`SFM_OFF_STATUS);
        chk(d, 32'h401);
        rd(`SFM_OFF_STATE);
        chk(d & 32'hf, 32'(ST_INIT));
        $display("test pair fault done");
        // past the first window a bad refresh counts toward the limit and fails only on reaching it
        step(10240);
        bad <= 1'b1;
        step(1);
        bad <= 1'b0;
        rd(`SFM_OFF_STATE);
        chk((d >> 8) & 32'h1f, 32'h12);
        ok <= 1'b1;
        step(1);
        ok <= 1'b0;
        rd(`SFM_OFF_STATE);
        chk((d >> 8) & 32'hf, 32'h1);
        repeat (3) begin
            bad <= 1'b1;
            step(1);
            bad <= 1'b0;
            step(1);
        end
        rd(`SFM_OFF_STATE);
        chk((d >> 4) & 32'hff, 32'h2);
        $display("test watchdog limit done");
        en1 <= 1'b0;
        step(3);
        rd(`SFM_OFF_STATE);
        chk(d & 32'hf, 32'(ST_OFF));
        sh <= 3'b001;
        st <= 1'b1;
        en1 <= 1'b1;
        step(4);
        rd(`SFM_OFF_STATUS);
        chk((d >> 5) & 32'h7, 32'h1);
        rd(`SFM_OFF_STATE);
        chk(d & 32'hf, 32'(ST_TEST));
        $display("test self test done");
        end_sim;
    end
endmodule
`default_nettype wire
